// ---- logic/cio_converter_ctrl.sv ----
// Purpose: Control of an eight-pin port acting as DAC, ADC or GPIO.
// Assumes: adc_data_i is settled by the end of a conversion; SCL/SDA and
//   gpio_in_i are asynchronous and are synchronised here.
// Notes: Only the address byte of a serial frame is watched here.
`timescale 1ns/100ps

// How it works
// - Each pin independently DAC, ADC or GPIO.
// - Config registers set roles; device applies them.
// - Bit 4 selects gain two, all DACs.
// - DAC codes are 12-bit straight binary.
// - Default mode: output follows input register directly.
// - Deferred mode holds outputs until a load.
// - Software load copies pending codes to outputs.
// - Each conversion lasts two microseconds, 12 bits.
// - Only channels in sequence register are converted.
// - Sequencer steps mux to next selected channel.
// - Sequence write puts first channel into track.
// - At least 500 ns tracking before conversion.
// - Conversion starts at address acknowledge clock rise.
// - Track on sequence write, hold on conversion.
// - Bit 5 selects ADC range, straight binary.
// - Pin both DAC and ADC acts as DAC.
module cio_converter_ctrl #(
  parameter logic [6:0] SLV_ADDR = cio_pkg::SLV_ADDR_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] gpio_in_i,
  input wire logic [11:0] adc_data_i,
  output logic [95:0] dac_code_o,
  output logic dac_gain2_o,
  output logic adc_gain2_o,
  output logic [7:0] pin_dac_en_o,
  output logic [7:0] pin_adc_en_o,
  output logic [7:0] gpio_oe_o,
  output logic [7:0] gpio_out_o,
  output logic [2:0] adc_mux_o,
  output logic adc_track_o,
  output logic adc_convert_o
);
  localparam int TRK_W = cio_pkg::TRACK_CYC;
  localparam int TRK_HI = cio_pkg::TRACK_CYC + 1;
  // Push lands CONV_CYC cycles after the convert pulse; 8 sit in the guard
  localparam int CONV_GAP = cio_pkg::CONV_CYC - 8;

  logic [7:0] adc_cfg, dac_cfg, gpo_cfg, gpi_cfg, gen_ctrl;
  logic [7:0] seq_mask, gpio_out_reg;
  logic defer;
  logic [11:0] dac_in [cio_pkg::NCH];
  logic [11:0] dac_out [cio_pkg::NCH];
  logic [31:0] next_rdata;
  logic [7:0] gpi_m, gpi_s;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic in_addr, addr_ack;
  logic [3:0] bitn;
  logic [7:0] shreg;
  cio_pkg::cio_seq_e st;
  logic [2:0] cur;
  logic [7:0] left;
  logic run;
  logic [5:0] cnt;
  logic [11:0] res;
  logic f_in_ready, f_out_valid, fifo_push, fifo_pop;
  logic [15:0] f_out_data;
  logic [5:0] trk_len;

  function automatic logic [2:0] first_ch(input logic [7:0] m);
    logic [2:0] f;
    f = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction : first_ch

  // Bus decode: one access per request, ack drops the cycle after
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i;
  wire rd = acc & ~wb_we_i;
  wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
  wire wr_lo = wr & wb_sel_i[0];
  wire wr_hi = wr & wb_sel_i[1];
  wire load_cmd = wr & (adr == cio_pkg::A_LOAD_CMD);
  wire seq_wr = wr_lo & (adr == cio_pkg::A_ADC_SEQ);
  wire [7:0] new_seq = wb_dat_i[7:0];
  wire [7:0] left_after = left & ~(8'h01 << cur);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_cfg <= cio_pkg::CFG_RST;
      dac_cfg <= cio_pkg::CFG_RST;
      gpo_cfg <= cio_pkg::CFG_RST;
      gpi_cfg <= cio_pkg::CFG_RST;
      gen_ctrl <= cio_pkg::CFG_RST;
      seq_mask <= cio_pkg::CFG_RST;
      gpio_out_reg <= cio_pkg::CFG_RST;
      defer <= 1'b0;
    end else if (wr_lo) begin
      case (adr)
        cio_pkg::A_ADC_CFG: adc_cfg <= wb_dat_i[7:0];
        cio_pkg::A_DAC_CFG: dac_cfg <= wb_dat_i[7:0];
        cio_pkg::A_GPO_CFG: gpo_cfg <= wb_dat_i[7:0];
        cio_pkg::A_GPI_CFG: gpi_cfg <= wb_dat_i[7:0];
        cio_pkg::A_GEN_CTRL: gen_ctrl <= wb_dat_i[7:0];
        cio_pkg::A_ADC_SEQ: seq_mask <= new_seq;
        cio_pkg::A_GPIO_OUT: gpio_out_reg <= wb_dat_i[7:0];
        cio_pkg::A_LOAD_CTRL: defer <= wb_dat_i[cio_pkg::DEFER_BIT];
        default: begin
        end
      endcase
    end
  end

  // Per-channel DAC input and output registers
  for (genvar g = 0; g < cio_pkg::NCH; g++) begin : g_dac
    wire hit = (adr == cio_pkg::A_DAC_BASE + 8'(4 * g));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dac_in[g] <= cio_pkg::CODE_RST;
      end else begin
        if (wr_lo && hit) begin
          dac_in[g][7:0] <= wb_dat_i[7:0];
        end
        if (wr_hi && hit) begin
          dac_in[g][11:8] <= wb_dat_i[11:8];
        end
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dac_out[g] <= cio_pkg::CODE_RST;
      end else if (load_cmd || !defer) begin
        dac_out[g] <= dac_in[g];
      end
    end
    assign dac_code_o[g*12 +: 12] = dac_out[g];
  end

  // Pin roles; DAC wins over ADC and GPIO on a shared pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_dac_en_o <= 8'h00;
      pin_adc_en_o <= 8'h00;
      gpio_oe_o <= 8'h00;
      gpio_out_o <= 8'h00;
      dac_gain2_o <= 1'b0;
      adc_gain2_o <= 1'b0;
    end else begin
      pin_dac_en_o <= dac_cfg;
      pin_adc_en_o <= adc_cfg & ~dac_cfg;
      gpio_oe_o <= gpo_cfg & ~dac_cfg & ~adc_cfg;
      gpio_out_o <= gpio_out_reg;
      dac_gain2_o <= gen_ctrl[cio_pkg::DAC_RANGE_BIT];
      adc_gain2_o <= gen_ctrl[cio_pkg::ADC_RANGE_BIT];
    end
  end

  // Synchronisers for pins from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpi_m <= 8'h00;
      gpi_s <= 8'h00;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      gpi_m <= gpio_in_i;
      gpi_s <= gpi_m;
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // Address byte watcher; ninth rising edge is the acknowledge clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_addr <= 1'b0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      addr_ack <= 1'b0;
    end else begin
      addr_ack <= 1'b0;
      if (start_seen) begin
        in_addr <= 1'b1;
        bitn <= 4'h0;
      end else if (stop_seen) begin
        in_addr <= 1'b0;
      end else if (in_addr && scl_rise) begin
        if (bitn == 4'h8) begin
          in_addr <= 1'b0;
          addr_ack <= (shreg[7:1] == SLV_ADDR);
        end else begin
          shreg <= {shreg[6:0], sda_s};
          bitn <= bitn + 4'h1;
        end
      end
    end
  end

  // Sequencer: an acknowledge runs every selected channel once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= cio_pkg::SEQ_IDLE;
      cur <= 3'h0;
      left <= 8'h00;
      run <= 1'b0;
      cnt <= 6'h00;
      res <= 12'h000;
      adc_track_o <= 1'b0;
      adc_convert_o <= 1'b0;
    end else begin
      adc_convert_o <= 1'b0;
      if (seq_wr) begin
        // A new sequence aborts any run in progress
        run <= 1'b0;
        cnt <= 6'h00;
        left <= new_seq;
        cur <= first_ch(new_seq);
        adc_track_o <= (new_seq != 8'h00);
        st <= (new_seq != 8'h00) ? cio_pkg::SEQ_TRACK
                                 : cio_pkg::SEQ_IDLE;
      end else begin
        case (st)
          cio_pkg::SEQ_IDLE: begin
            adc_track_o <= 1'b0;
          end
          cio_pkg::SEQ_TRACK: begin
            if (cnt < cio_pkg::TRACK_CNT) begin
              cnt <= cnt + 6'h01;
            end
            if (addr_ack) begin
              run <= 1'b1;
            end
            // An early acknowledge waits out the track time
            if ((run || addr_ack) && cnt >= cio_pkg::TRACK_CNT) begin
              st <= cio_pkg::SEQ_CONV;
              cnt <= 6'h00;
              adc_track_o <= 1'b0;
              adc_convert_o <= 1'b1;
            end
          end
          cio_pkg::SEQ_CONV: begin
            cnt <= cnt + 6'h01;
            if (cnt == cio_pkg::CONV_LAST) begin
              res <= adc_data_i;
              st <= cio_pkg::SEQ_PUSH;
            end
          end
          cio_pkg::SEQ_PUSH: begin
            // Full FIFO holds the sequencer here
            if (f_in_ready) begin
              if (left_after != 8'h00) begin
                cur <= first_ch(left_after);
                left <= left_after;
              end else begin
                cur <= first_ch(seq_mask);
                left <= seq_mask;
                run <= 1'b0;
              end
              st <= cio_pkg::SEQ_TRACK;
              cnt <= 6'h00;
              adc_track_o <= 1'b1;
            end
          end
          default: begin
            st <= cio_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
  end

  assign adc_mux_o = cur;
  assign fifo_push = (st == cio_pkg::SEQ_PUSH);
  assign fifo_pop = rd & (adr == cio_pkg::A_ADC_RES) & f_out_valid;

  cio_fifo #(
    .W(cio_pkg::RES_W),
    .DEPTH(cio_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_data_i({1'b0, cur, res}),
    .in_ready_o(f_in_ready),
    .out_valid_o(f_out_valid),
    .out_data_o(f_out_data),
    .out_ready_i(fifo_pop)
  );

  // Read data; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (adr)
      cio_pkg::A_ADC_CFG: next_rdata[7:0] = adc_cfg;
      cio_pkg::A_DAC_CFG: next_rdata[7:0] = dac_cfg;
      cio_pkg::A_GPO_CFG: next_rdata[7:0] = gpo_cfg;
      cio_pkg::A_GPI_CFG: next_rdata[7:0] = gpi_cfg;
      cio_pkg::A_GEN_CTRL: next_rdata[7:0] = gen_ctrl;
      cio_pkg::A_ADC_SEQ: next_rdata[7:0] = seq_mask;
      cio_pkg::A_LOAD_CTRL: next_rdata[cio_pkg::DEFER_BIT] = defer;
      cio_pkg::A_ADC_RES: begin
        if (f_out_valid) begin
          next_rdata[15:0] = f_out_data;
          next_rdata[cio_pkg::RES_VALID_BIT] = 1'b1;
        end
      end
      cio_pkg::A_STATUS: begin
        next_rdata[0] = f_out_valid;
        next_rdata[1] = run;
        next_rdata[4:2] = cur;
        next_rdata[6:5] = st;
        next_rdata[7] = ~f_in_ready;
      end
      cio_pkg::A_GPIO_OUT: next_rdata[7:0] = gpio_out_reg;
      cio_pkg::A_GPIO_IN: next_rdata[7:0] = gpi_s & gpi_cfg;
      default: begin
        if (adr[7:5] == cio_pkg::DAC_PAGE) begin
          next_rdata[11:0] = dac_in[adr[4:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Length of the current track phase, read only by checks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trk_len <= 6'h00;
    end else if (!adc_track_o) begin
      trk_len <= 6'h00;
    end else if (trk_len != 6'h3f) begin
      trk_len <= trk_len + 6'h01;
    end
  end

  dac_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !defer |=> dac_out[3] == $past(dac_in[3]))
    else $error("DAC output did not follow input register");
  dac_defer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (defer && !load_cmd) |=> $stable(dac_code_o))
    else $error("Deferred DAC output changed without load");
  dac_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> dac_out[0] == $past(dac_in[0]))
    else $error("Load did not transfer pending code");
  range_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(gen_ctrl) |=> ##1
      dac_gain2_o == gen_ctrl[cio_pkg::DAC_RANGE_BIT] &&
      adc_gain2_o == gen_ctrl[cio_pkg::ADC_RANGE_BIT])
    else $error("Range outputs do not follow control bits");
  conv_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adc_convert_o && !seq_wr) ##1 !seq_wr [*8] |->
      ##[CONV_GAP:CONV_GAP] fifo_push)
    else $error("Conversion result not ready after conversion time");
  seq_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_push |-> seq_mask[cur])
    else $error("Unselected channel converted");
  seq_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fifo_push && f_in_ready && left_after != 8'h00 && !seq_wr) |=>
      st == cio_pkg::SEQ_TRACK && cur != $past(cur))
    else $error("Sequencer did not advance channel");
  seq_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_wr && new_seq != 8'h00) |=>
      adc_track_o && adc_mux_o == first_ch($past(new_seq)))
    else $error("First channel not tracking after sequence write");
  track_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_convert_o |-> trk_len >= 6'(TRK_W) && !adc_track_o)
    else $error("Conversion began before minimum track time");
  ack_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (addr_ack && st == cio_pkg::SEQ_TRACK && !seq_wr) ##1 !seq_wr |->
      ##[0:TRK_HI] adc_convert_o)
    else $error("Acknowledge did not start a conversion");
  empty_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_mask == 8'h00 && $past(seq_mask) == 8'h00) |->
      !adc_convert_o && !adc_track_o)
    else $error("Conversion activity with empty sequence");
  dac_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_adc_en_o & pin_dac_en_o) == 8'h00)
    else $error("Pin enabled as both DAC and ADC output role");
endmodule : cio_converter_ctrl

// ---- logic/cio_pkg.sv ----
// Purpose: Shared constants for the configurable I/O converter control.
// Assumes: 25 MHz system clock; byte addresses on a 32-bit Wishbone bus.
// Notes: Offsets are word aligned; narrow registers sit in the low bits.
package cio_pkg;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned TRACK_NS = 500;
  localparam int unsigned CONV_NS = 2000;
  // Least time rounds up, longest time rounds down
  localparam int unsigned TRACK_CYC = (TRACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_CYC =
    (CONV_NS / CLK_NS < 1) ? 1 : CONV_NS / CLK_NS;
  localparam logic [5:0] TRACK_CNT = 6'(TRACK_CYC);
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYC - 1);

  localparam int NCH = 8;
  localparam int CODE_W = 12;
  localparam int RES_W = 16;
  localparam int FIFO_DEPTH = 16;

  localparam logic [7:0] A_ADC_CFG = 8'h00;
  localparam logic [7:0] A_DAC_CFG = 8'h04;
  localparam logic [7:0] A_GPO_CFG = 8'h08;
  localparam logic [7:0] A_GPI_CFG = 8'h0c;
  localparam logic [7:0] A_GEN_CTRL = 8'h10;
  localparam logic [7:0] A_ADC_SEQ = 8'h14;
  localparam logic [7:0] A_LOAD_CTRL = 8'h18;
  localparam logic [7:0] A_LOAD_CMD = 8'h1c;
  localparam logic [7:0] A_ADC_RES = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_GPIO_OUT = 8'h28;
  localparam logic [7:0] A_GPIO_IN = 8'h2c;
  localparam logic [7:0] A_DAC_BASE = 8'h40;
  localparam logic [2:0] DAC_PAGE = 3'h2;

  localparam int DAC_RANGE_BIT = 4;
  localparam int ADC_RANGE_BIT = 5;
  localparam int DEFER_BIT = 0;
  localparam int RES_VALID_BIT = 16;

  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [6:0] SLV_ADDR_DEF = 7'h10;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TRACK = 2'b01,
    SEQ_CONV = 2'b10,
    SEQ_PUSH = 2'b11
  } cio_seq_e;
endpackage : cio_pkg

// ---- logic/cio_fifo.sv ----
// Purpose: Result FIFO between the ADC sequencer and the register bus.
// Assumes: Single clock; push and pop in one cycle are allowed.
// Notes: Full stalls the source through in_ready_o.
`timescale 1ns/100ps
module cio_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rptr];
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : cio_fifo

// ---- dv/cio_i2c_master.sv ----
// Purpose: Serial bus master model that addresses the converter control.
// Assumes: 320 ns link clock; open-drain lines with pull-ups.
// Notes: SCL stands high between frames; released SDA reads high.
`timescale 1ns/100ps
module cio_i2c_master (
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Odd start offset keeps the link out of phase with the system clock
  task automatic frame(input logic [6:0] adr, input logic rd);
    logic [7:0] b;
    b = {adr, rd};
    #23 sda_o = 1'b0;
    #160 scl_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #40 sda_o = b[i];
      #120 scl_o = 1'b1;
      #160 scl_o = 1'b0;
    end
    // Ninth pulse: SDA released, pull-up holds it high
    #40 sda_o = 1'b1;
    #120 scl_o = 1'b1;
    #160 scl_o = 1'b0;
    #40 sda_o = 1'b0;
    #120 scl_o = 1'b1;
    #80 sda_o = 1'b1;
  endtask : frame
endmodule : cio_i2c_master

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the converter control block.
// Assumes: Design answers every bus request; results in a 16-word FIFO.
// Notes: Conversion results are modelled in queues and compared in order.
`timescale 1ns/100ps
module testbench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, scl, sda;
  logic dac_gain2_o, adc_gain2_o, adc_track_o, adc_convert_o;
  logic [7:0] wb_adr_i, gpio_in_i, pin_dac_en_o, pin_adc_en_o;
  logic [7:0] gpio_oe_o, gpio_out_o, a, d, g, mask;
  logic [31:0] wb_dat_i, wb_dat_o, rd, v, mv;
  logic [3:0] wb_sel_i;
  logic [11:0] adc_data_i;
  logic [95:0] dac_code_o, exp_dac;
  logic [2:0] adc_mux_o;
  logic [14:0] res_q[$];
  int exp_ch[$];
  int errors, compares, trk, gap, seed, n;

  cio_converter_ctrl cio_converter_ctrl_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .scl_i(scl), .sda_i(sda), .gpio_in_i, .adc_data_i,
    .dac_code_o, .dac_gain2_o, .adc_gain2_o, .pin_dac_en_o, .pin_adc_en_o,
    .gpio_oe_o, .gpio_out_o, .adc_mux_o, .adc_track_o, .adc_convert_o);
  cio_i2c_master cio_i2c_master_i (.scl_o(scl), .sda_o(sda));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [95:0] e,
                     input logic [95:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] dt, input logic [3:0] sl);
    int k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dt;
    wb_sel_i <= sl;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20) chk("bus ack", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdres();
    logic [14:0] e;
    wb(0, cio_pkg::A_ADC_RES, 0, 4'hf);
    if (res_q.size() == 0) chk("result empty", 0, rd[16]);
    else begin
      e = res_q.pop_front();
      chk("result", {1'b1, e}, {rd[16], rd[14:0]});
    end
  endtask : rdres

  task automatic go(input logic [6:0] adr);
    for (int i = 0; i < 8; i++) if (mask[i]) exp_ch.push_back(i);
    cio_i2c_master_i.frame(adr, 1'b0);
  endtask : go

  task automatic settle();
    n = 0;
    while (exp_ch.size() != 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) chk("settle timeout", 0, 1);
    repeat (70) @(posedge clk_i);
  endtask : settle

  // Conversion monitor and result model
  always @(posedge clk_i) begin
    if (rst_i) begin
      trk = 0;
      gap = -1;
      adc_data_i <= 12'h000;
    end else begin
      if (gap >= 0) gap++;
      if (adc_convert_o === 1'b1) begin
        chk("track time", 1, trk >= cio_pkg::TRACK_CYC);
        chk("hold at start", 0, adc_track_o);
        if (exp_ch.size() == 0) chk("stray convert", 0, 1);
        else chk("mux", exp_ch.pop_front(), adc_mux_o);
        mv = $random(seed);
        adc_data_i <= mv[11:0];
        res_q.push_back({adc_mux_o, mv[11:0]});
        gap = 0;
      end
      if (adc_track_o === 1'b1 && trk == 0 && gap > 0) begin
        chk("conversion time", 1, gap >= cio_pkg::CONV_CYC);
        gap = -1;
      end
      trk = (adc_track_o === 1'b1) ? trk + 1 : 0;
    end
  end

  initial begin
    #1000000;
    errors++;
    complete_run();
  end

  initial begin
    seed = 32'h627deae9;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    gpio_in_i = 8'h00;
    exp_dac = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset codes", 0, dac_code_o);
    chk("reset gains", 0, {dac_gain2_o, adc_gain2_o});
    repeat (4) begin
      v = $random(seed);
      {a, d, g} = v[23:0];
      wb(1, cio_pkg::A_ADC_CFG, a, 4'hf);
      wb(1, cio_pkg::A_DAC_CFG, d, 4'hf);
      wb(1, cio_pkg::A_GPO_CFG, g, 4'hf);
      wb(1, cio_pkg::A_GPIO_OUT, v[31:24], 4'hf);
      chk("dac pins", d, pin_dac_en_o);
      chk("adc pins", a & ~d, pin_adc_en_o);
      chk("gpio oe", g & ~d & ~a, gpio_oe_o);
      chk("gpio out", v[31:24], gpio_out_o);
    end
    gpio_in_i <= v[7:0];
    wb(1, cio_pkg::A_GPI_CFG, 8'hff, 4'hf);
    repeat (3) @(posedge clk_i);
    wb(0, cio_pkg::A_GPIO_IN, 0, 4'hf);
    chk("gpio in", v[7:0], rd[7:0]);
    for (int i = 0; i < 4; i++) begin
      wb(1, cio_pkg::A_GEN_CTRL, 32'(i) << 4, 4'hf);
      chk("dac range", i % 2, dac_gain2_o);
      chk("adc range", i / 2, adc_gain2_o);
    end
    for (int c = 0; c < 8; c++) begin
      v = (c == 7) ? 32'h0fff : $random(seed);
      wb(1, 8'(cio_pkg::A_DAC_BASE + 8'(4 * c)), v, 4'hf);
      exp_dac[12*c +: 12] = v[11:0];
      chk("dac code", exp_dac, dac_code_o);
    end
    wb(1, cio_pkg::A_DAC_BASE, 32'h0000_0a5c, 4'h1);
    exp_dac[7:0] = 8'h5c;
    chk("dac lane", exp_dac, dac_code_o);
    wb(1, cio_pkg::A_LOAD_CTRL, 1, 4'hf);
    v = $random(seed);
    wb(1, 8'h48, v, 4'hf);
    wb(1, 8'h54, v >> 12, 4'hf);
    repeat (3) @(posedge clk_i);
    chk("deferred hold", exp_dac, dac_code_o);
    exp_dac[35:24] = v[11:0];
    exp_dac[71:60] = v[23:12];
    wb(1, cio_pkg::A_LOAD_CMD, 0, 4'hf);
    chk("load command", exp_dac, dac_code_o);
    wb(1, cio_pkg::A_LOAD_CTRL, 0, 4'hf);
    wb(0, 8'h3c, 0, 4'hf);
    chk("unmapped read", 0, rd);
    rdres();
    mask = 8'h00;
    wb(1, cio_pkg::A_ADC_SEQ, mask, 4'hf);
    chk("empty seq idle", 0, adc_track_o);
    go(cio_pkg::SLV_ADDR_DEF);
    settle();
    v = $random(seed);
    mask = v[7:0] | 8'h08;
    wb(1, cio_pkg::A_ADC_SEQ, mask, 4'hf);
    chk("seq track", 1, adc_track_o);
    for (int i = 7; i >= 0; i--) if (mask[i]) a = 8'(i);
    chk("seq first", a[2:0], adc_mux_o);
    cio_i2c_master_i.frame(cio_pkg::SLV_ADDR_DEF ^ 7'h01, 1'b0);
    repeat (100) @(posedge clk_i);
    go(cio_pkg::SLV_ADDR_DEF);
    settle();
    while (res_q.size() != 0) rdres();
    rdres();
    mask = 8'hff;
    wb(1, cio_pkg::A_ADC_SEQ, mask, 4'hf);
    go(cio_pkg::SLV_ADDR_DEF);
    settle();
    go(cio_pkg::SLV_ADDR_DEF);
    settle();
    go(cio_pkg::SLV_ADDR_DEF);
    repeat (100) @(posedge clk_i);
    wb(0, cio_pkg::A_STATUS, 0, 4'hf);
    chk("fifo full", 1, rd[7]);
    repeat (16) rdres();
    settle();
    while (res_q.size() != 0) rdres();
    rdres();
    complete_run();
  end
endmodule : testbench
